// *** scp_pkg.sv ***
// constants, types and register map for the serial channel pin selection block
package scp_pkg;

   localparam int unsigned SCP_NCH       = 4;
   localparam int unsigned SCP_ADDR_W    = 8;
   localparam int unsigned SCP_CFG_W     = 9;
   localparam int unsigned SCP_STAT_W    = 5;
   localparam int unsigned SCP_STRIDE    = 4;

   localparam logic [SCP_ADDR_W-1:0] SCP_CFG_BASE  = 8'h00;
   localparam logic [SCP_ADDR_W-1:0] SCP_STAT_BASE = 8'h10;

   localparam logic [1:0] SCP_RESP_OKAY   = 2'h0;
   localparam logic [1:0] SCP_RESP_SLVERR = 2'h2;

   // clock modes 0 to 7, in order
   typedef enum logic [2:0] {
      SCP_CM0, SCP_CM1, SCP_CM2, SCP_CM3,
      SCP_CM4, SCP_CM5, SCP_CM6, SCP_CM7
   } scp_mode_t;

   // one channel's configuration word, msb first
   typedef struct packed {
      logic      rts_req;
      logic      transmit_clock_out_enable;
      logic      open_drain;
      logic      timeslot_out_enable;
      logic      source_select;
      logic      transmit_clock_output_enable;
      scp_mode_t mode;
   } scp_cfg_t;

   localparam scp_cfg_t SCP_CFG_RST = 9'h000;

   // pin levels seen from the line
   typedef struct packed {
      logic receive_clock_pin;
      logic transmit_clock_pin;
      logic rxd;
      logic cts_n;
   } scp_pin_in_t;

   // pin drivers toward the line
   typedef struct packed {
      logic transmit_clock_pin_o;
      logic transmit_clock_pin_oe;
      logic txd_o;
      logic txd_oe;
      logic rts_n;
   } scp_pin_out_t;

   // selected clocks and strobes toward the channel core
   typedef struct packed {
      logic rx_clock;
      logic tx_clock;
      logic brg_ref;
      logic tx_enable;
      logic rx_sample;
      logic rx_bit;
   } scp_core_t;

endpackage

// *** scp_sync.sv ***
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ns
`default_nettype none
module scp_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   import scp_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } scp_sync_state_t;

   scp_sync_state_t state_reg;
   scp_sync_state_t state_next;

   // first stage feeds only the second
   always_comb begin
      state_next    = state_reg;
      state_next.s1 = d;
      state_next.s2 = state_reg.s1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign q = state_reg.s2;

endmodule // scp_sync
`default_nettype wire

// *** scp_serial_channel_pins.sv ***
// per-channel clock and data pin selection with an axi4-lite register slave
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Function
// [R1] every channel owns its clock and data pins, chosen by its own clock mode
// [R2] modes 0 and 4: receive clock pin is only the receiver's bit clock
// [R3] modes 1 and 5: receive clock pin clocks receiver and transmitter
// [R4] modes 2 and 3: receive clock pin is the baud generator's reference
// [R5] output enable off, source select clear, modes 0,2,4,6: transmit clock pin is input clock
// [R6] mode 1 with transmit clock pin as input: pin is a transmit strobe
// [R7] output enable on, source select set, modes 2,3,6,7: drive baud generator clock
// [R8] output enable on, source select clear, modes 3,7: drive recovered dpll clock
// [R9] mode 5 with time-slot enable: drive active-low time-slot marker on transmit clock pin
// [R10] transmit bit stream leaves on the transmit data pin
// [R11] transmit data pin is push-pull or open-drain by a configuration bit
// [R12] far end presents receive data, sampled by the selected receive clock
// [R13] mode 4 with clock-out enable: internal transmit clock goes to request-to-send pin
// [R14] clear-to-send low enables the transmitter, high holds it off
// [R15] clock mode is a three-bit software setting per channel
// [R16] transmit clock pin as input keeps its driver off
module scp_serial_channel_pins #(
   parameter int unsigned NCH = scp_pkg::SCP_NCH
) (
   input  wire logic                             aclk,
   input  wire logic                             aresetn,
   input  wire logic [scp_pkg::SCP_ADDR_W-1:0]   awaddr,
   input  wire logic                             awvalid,
   output logic                                  awready,
   input  wire logic [31:0]                      wdata,
   input  wire logic [3:0]                       wstrb,
   input  wire logic                             wvalid,
   output logic                                  wready,
   output logic [1:0]                            bresp,
   output logic                                  bvalid,
   input  wire logic                             bready,
   input  wire logic [scp_pkg::SCP_ADDR_W-1:0]   araddr,
   input  wire logic                             arvalid,
   output logic                                  arready,
   output logic [31:0]                           rdata,
   output logic [1:0]                            rresp,
   output logic                                  rvalid,
   input  wire logic                             rready,
   input  wire scp_pkg::scp_pin_in_t [NCH-1:0]   pin_in,
   output scp_pkg::scp_pin_out_t [NCH-1:0]       pin_out,
   input  wire logic [NCH-1:0]                   tx_bit,
   input  wire logic [NCH-1:0]                   tx_timeslot,
   input  wire logic [NCH-1:0]                   brg_clk,
   input  wire logic [NCH-1:0]                   dpll_clk,
   output scp_pkg::scp_core_t [NCH-1:0]          core_out
);
   import scp_pkg::*;

   typedef struct packed {
      scp_cfg_t [NCH-1:0]       cfg;
      logic                     aw_held;
      logic [SCP_ADDR_W-1:0]    aw_addr;
      logic                     w_held;
      logic [31:0]              w_data;
      logic [3:0]               w_strb;
      logic                     awready;
      logic                     wready;
      logic                     bvalid;
      logic [1:0]               bresp;
      logic                     arready;
      logic                     rvalid;
      logic [1:0]               rresp;
      logic [31:0]              rdata;
      logic [NCH-1:0]           rxc_prev;
      scp_pin_out_t [NCH-1:0]   pin_o;
      scp_core_t [NCH-1:0]      core;
   } scp_top_state_t;

   scp_top_state_t           state_reg;
   scp_top_state_t           state_next;
   scp_pin_in_t [NCH-1:0]    pin_s;

   ////////////////////////////////////////////////////////////////////////
   // pins come from the line clock, so every level is synchronised first

   scp_sync #(
      .W       (NCH * $bits(scp_pin_in_t))
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (pin_in),
      .q       (pin_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // returns {hit, index} of a word register in a per-channel bank
   function automatic logic [4:0] reg_sel(
      input logic [SCP_ADDR_W-1:0] a,
      input logic [SCP_ADDR_W-1:0] base
   );
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < NCH; i++) begin
         if (a == base + SCP_ADDR_W'(i * SCP_STRIDE)) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction

   // byte-lane merge of a write into an old word
   function automatic logic [31:0] wmerge(
      input logic [31:0] old,
      input logic [31:0] d,
      input logic [3:0]  strb
   );
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      scp_cfg_t    c;
      scp_pin_in_t p;
      logic [4:0]  sel;
      logic [31:0] wm;
      logic        rxc, txc, drv, mk, txe, bit_o;
      c          = SCP_CFG_RST;
      p          = '0;
      sel        = 5'h00;
      wm         = 32'h0000_0000;
      rxc        = 1'b0;
      txc        = 1'b0;
      drv        = 1'b0;
      mk         = 1'b0;
      txe        = 1'b0;
      bit_o      = 1'b0;
      state_next = state_reg;

      // write channel: address and data taken in either order
      if (awvalid && state_reg.awready) begin
         state_next.aw_held = 1'b1;
         state_next.aw_addr = awaddr;
      end
      if (wvalid && state_reg.wready) begin
         state_next.w_held = 1'b1;
         state_next.w_data = wdata;
         state_next.w_strb = wstrb;
      end
      if (state_reg.bvalid && bready) begin
         state_next.bvalid = 1'b0;
      end
      // only the configuration bank is writable; status is read-only
      if (state_reg.aw_held && state_reg.w_held && !state_reg.bvalid) begin
         sel = reg_sel(state_reg.aw_addr, SCP_CFG_BASE);
         if (sel[4]) begin
            wm = wmerge({{(32-SCP_CFG_W){1'b0}}, state_reg.cfg[sel[3:0]]},
                        state_reg.w_data, state_reg.w_strb);
            state_next.cfg[sel[3:0]] = scp_cfg_t'(wm[SCP_CFG_W-1:0]); // see [R15]
            state_next.bresp         = SCP_RESP_OKAY;
         end else begin
            state_next.bresp = SCP_RESP_SLVERR;
         end
         state_next.bvalid  = 1'b1;
         state_next.aw_held = 1'b0;
         state_next.w_held  = 1'b0;
      end

      // read channel
      if (state_reg.rvalid && rready) begin
         state_next.rvalid = 1'b0;
      end
      if (arvalid && state_reg.arready) begin
         state_next.rvalid = 1'b1;
         state_next.rresp  = SCP_RESP_OKAY;
         state_next.rdata  = 32'h0000_0000;
         sel = reg_sel(araddr, SCP_CFG_BASE);
         if (sel[4]) begin
            state_next.rdata = {{(32-SCP_CFG_W){1'b0}}, state_reg.cfg[sel[3:0]]};
         end else begin
            sel = reg_sel(araddr, SCP_STAT_BASE);
            if (sel[4]) begin
               state_next.rdata = {{(32-SCP_STAT_W){1'b0}},
                                   state_reg.core[sel[3:0]].tx_enable,
                                   pin_s[sel[3:0]]};
            end else begin
               state_next.rresp = SCP_RESP_SLVERR;
            end
         end
      end

      state_next.awready = !state_next.aw_held;
      state_next.wready  = !state_next.w_held;
      state_next.arready = !state_next.rvalid;

      // pin roles, each channel on its own configuration
      for (int i = 0; i < NCH; i++) begin // see [R1]
         c = state_reg.cfg[i];
         p = pin_s[i];

         // receiver clock: the pin in modes 0,1,4,5, else generated
         if (c.mode inside {SCP_CM0, SCP_CM1, SCP_CM4, SCP_CM5}) begin
            rxc = p.receive_clock_pin; // see [R2]
         end else if (c.mode inside {SCP_CM3, SCP_CM7}) begin
            rxc = dpll_clk[i];
         end else begin
            rxc = brg_clk[i];
         end

         // transmitter clock
         if (c.mode inside {SCP_CM1, SCP_CM5}) begin
            txc = p.receive_clock_pin; // see [R3]
         end else if (!c.transmit_clock_output_enable) begin
            if (!c.source_select && c.mode inside {SCP_CM0, SCP_CM2, SCP_CM4, SCP_CM6}) begin
               txc = p.transmit_clock_pin; // see [R5]
            end else begin
               txc = brg_clk[i];
            end
         end else if (c.source_select && c.mode inside {SCP_CM2, SCP_CM3, SCP_CM6, SCP_CM7}) begin
            txc = brg_clk[i]; // see [R7]
         end else if (c.mode inside {SCP_CM3, SCP_CM7}) begin
            txc = dpll_clk[i]; // see [R8]
         end else begin
            txc = brg_clk[i];
         end

         // pin driver on only for the generated clock or the time-slot marker
         drv = c.transmit_clock_output_enable &&
               ((c.source_select && c.mode inside {SCP_CM2, SCP_CM3, SCP_CM6, SCP_CM7}) ||
                (!c.source_select && c.mode inside {SCP_CM3, SCP_CM7}));
         mk  = (c.mode == SCP_CM5) && c.timeslot_out_enable;
         if (mk) begin
            state_next.pin_o[i].transmit_clock_pin_o = !tx_timeslot[i]; // see [R9]
         end else begin
            state_next.pin_o[i].transmit_clock_pin_o = txc;
         end
         state_next.pin_o[i].transmit_clock_pin_oe = mk || drv; // see [R16]

         // clear-to-send gate, plus the strobe of mode 1 with an input pin
         txe = !p.cts_n; // see [R14]
         if (c.mode == SCP_CM1 && !c.transmit_clock_output_enable) begin
            txe = txe && p.transmit_clock_pin; // see [R6]
         end

         // idle mark while the transmitter is held off
         bit_o = txe ? tx_bit[i] : 1'b1; // see [R10]
         if (c.open_drain) begin
            state_next.pin_o[i].txd_o  = 1'b0; // see [R11]
            state_next.pin_o[i].txd_oe = !bit_o;
         end else begin
            state_next.pin_o[i].txd_o  = bit_o;
            state_next.pin_o[i].txd_oe = 1'b1;
         end

         if (c.mode == SCP_CM4 && c.transmit_clock_out_enable) begin
            state_next.pin_o[i].rts_n = txc; // see [R13]
         end else begin
            state_next.pin_o[i].rts_n = !c.rts_req;
         end

         // receive bit taken on the rising edge of the selected clock
         state_next.rxc_prev[i]       = rxc;
         state_next.core[i].rx_sample = rxc && !state_reg.rxc_prev[i]; // see [R12]
         if (rxc && !state_reg.rxc_prev[i]) begin
            state_next.core[i].rx_bit = p.rxd;
         end
         state_next.core[i].rx_clock  = rxc;
         state_next.core[i].tx_clock  = txc;
         state_next.core[i].tx_enable = txe;
         if (c.mode inside {SCP_CM2, SCP_CM3}) begin
            state_next.core[i].brg_ref = p.receive_clock_pin; // see [R4]
         end else begin
            state_next.core[i].brg_ref = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; line pins rest at mark, request-to-send inactive

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= '0;
         for (int i = 0; i < NCH; i++) begin
            state_reg.pin_o[i].txd_o  <= 1'b1;
            state_reg.pin_o[i].txd_oe <= 1'b1;
            state_reg.pin_o[i].rts_n  <= 1'b1;
         end
      end else begin
         state_reg <= state_next;
      end
   end

   assign awready  = state_reg.awready;
   assign wready   = state_reg.wready;
   assign bvalid   = state_reg.bvalid;
   assign bresp    = state_reg.bresp;
   assign arready  = state_reg.arready;
   assign rvalid   = state_reg.rvalid;
   assign rresp    = state_reg.rresp;
   assign rdata    = state_reg.rdata;
   assign pin_out  = state_reg.pin_o;
   assign core_out = state_reg.core;

   ////////////////////////////////////////////////////////////////////////
   // checks

   bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (bvalid && !bready) |=> (bvalid && $stable(bresp)))
      else $error("write response dropped before bready");
   rdata_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (rvalid && !rready) |=> (rvalid && $stable(rdata)))
      else $error("read data dropped before rready");
   cfg_by_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R15]
      (state_reg.cfg != $past(state_reg.cfg)) |-> $rose(bvalid))
      else $error("configuration changed without a write");

   for (genvar g = 0; g < NCH; g++) begin : g_chk
      rx_only_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R2]
         (state_reg.cfg[g].mode inside {SCP_CM0, SCP_CM4}) |=>
         (core_out[g].rx_clock == $past(pin_s[g].receive_clock_pin)) && !core_out[g].brg_ref)
         else $error("receive clock pin misused in mode 0 or 4");
      rx_tx_clock_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R3]
         (state_reg.cfg[g].mode inside {SCP_CM1, SCP_CM5}) |=>
         (core_out[g].tx_clock == $past(pin_s[g].receive_clock_pin)))
         else $error("transmitter not on receive clock pin");
      brg_ref_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R4]
         (state_reg.cfg[g].mode inside {SCP_CM2, SCP_CM3}) |=>
         (core_out[g].brg_ref == $past(pin_s[g].receive_clock_pin)))
         else $error("baud generator reference wrong");
      tx_clk_in_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R5]
         (!state_reg.cfg[g].transmit_clock_output_enable && !state_reg.cfg[g].source_select &&
          state_reg.cfg[g].mode inside {SCP_CM0, SCP_CM2, SCP_CM4, SCP_CM6}) |=>
         (core_out[g].tx_clock == $past(pin_s[g].transmit_clock_pin)))
         else $error("transmit clock not taken from pin");
      tx_strobe_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R6]
         (state_reg.cfg[g].mode == SCP_CM1 && !state_reg.cfg[g].transmit_clock_output_enable &&
          !pin_s[g].transmit_clock_pin) |=> !core_out[g].tx_enable)
         else $error("transmit strobe low did not gate transmitter");
      brg_out_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R7]
         (state_reg.cfg[g].transmit_clock_output_enable && state_reg.cfg[g].source_select &&
          state_reg.cfg[g].mode inside {SCP_CM2, SCP_CM3, SCP_CM6, SCP_CM7}) |=>
         (pin_out[g].transmit_clock_pin_oe && pin_out[g].transmit_clock_pin_o == $past(brg_clk[g])))
         else $error("baud generator clock not driven");
      dpll_out_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R8]
         (state_reg.cfg[g].transmit_clock_output_enable && !state_reg.cfg[g].source_select &&
          state_reg.cfg[g].mode inside {SCP_CM3, SCP_CM7}) |=>
         (pin_out[g].transmit_clock_pin_oe && pin_out[g].transmit_clock_pin_o == $past(dpll_clk[g])))
         else $error("dpll clock not driven");
      slot_mark_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R9]
         (state_reg.cfg[g].mode == SCP_CM5 && state_reg.cfg[g].timeslot_out_enable) |=>
         (pin_out[g].transmit_clock_pin_oe && pin_out[g].transmit_clock_pin_o == !$past(tx_timeslot[g])))
         else $error("time-slot marker wrong");
      open_drain_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R11]
         state_reg.cfg[g].open_drain |=> (!pin_out[g].txd_o))
         else $error("open-drain data pin driven high");
      cts_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R14]
         pin_s[g].cts_n |=> (!core_out[g].tx_enable && (pin_out[g].txd_o || !pin_out[g].txd_oe)))
         else $error("transmitter ran with clear-to-send high");
      rts_clock_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R13]
         (state_reg.cfg[g].mode == SCP_CM4 && state_reg.cfg[g].transmit_clock_out_enable) |=>
         (pin_out[g].rts_n == core_out[g].tx_clock))
         else $error("transmit clock not on request-to-send pin");
      clk_pin_in_a: assert property (@(posedge aclk) disable iff (!aresetn) // see [R16]
         (!state_reg.cfg[g].transmit_clock_output_enable &&
          !(state_reg.cfg[g].mode == SCP_CM5 && state_reg.cfg[g].timeslot_out_enable)) |=>
         !pin_out[g].transmit_clock_pin_oe)
         else $error("transmit clock pin driven while input");
   end

endmodule // scp_serial_channel_pins
`default_nettype wire

// *** scp_line_model.sv ***
// line-side model: remote clocks, receive data, flow control and the shared data line
`timescale 1ns/1ns
`default_nettype none
module scp_line_model #(
   parameter int unsigned NCH = 4
) (
   input  wire logic                            rcv_l,
   input  wire logic                            ext_l,
   input  wire logic                            rxd_l,
   input  wire logic                            cts_l,
   input  wire scp_pkg::scp_pin_out_t [NCH-1:0] pin_out,
   output scp_pkg::scp_pin_in_t [NCH-1:0]       pin_in,
   output logic [NCH-1:0]                       txd_line
);
   import scp_pkg::*;
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         pin_in[i].receive_clock_pin = rcv_l;
         // a driven pin wins, otherwise the external clock source drives it
         pin_in[i].transmit_clock_pin = pin_out[i].transmit_clock_pin_oe ? pin_out[i].transmit_clock_pin_o : ext_l;
         pin_in[i].rxd = rxd_l;
         pin_in[i].cts_n = cts_l;
         // pull-up on the shared data line, released driver reads high
         txd_line[i] = pin_out[i].txd_oe ? pin_out[i].txd_o : 1'b1;
      end
   end
endmodule // scp_line_model
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the serial channel pin selection block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import scp_pkg::*;
   logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic              awready, wready, bvalid, arready, rvalid, rcv_l, ext_l, rxd_l, cts_l, ex_oe;
   logic [7:0]        awaddr, araddr;
   logic [31:0]       wdata, rdata, d;
   logic [3:0]        wstrb, tx_bit, tx_timeslot, brg_clk, dpll_clk, txd_line;
   logic [1:0]        bresp, rresp, r;
   scp_pin_in_t [3:0] pin_in;
   scp_pin_out_t [3:0] pin_out;
   scp_core_t [3:0]   core_out;
   int                mismatches, checks_done, cyc, ex_rx, ex_tx, pulses;
   scp_serial_channel_pins #(.NCH(4)) i_scp_serial_channel_pins (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .pin_in, .pin_out, .tx_bit, .tx_timeslot, .brg_clk, .dpll_clk, .core_out);
   scp_line_model #(.NCH(4)) i_scp_line_model (.rcv_l, .ext_l, .rxd_l, .cts_l, .pin_out, .pin_in, .txd_line);
   ////////////////////////////////////////////////////////////////////////////////
   initial aclk = 1'b0;
   always #2 aclk = ~aclk;
   // whole run is under a thousand cycles, so this only trips on a hang
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
      awaddr <= a; wdata <= dat; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      rs = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] q, output logic [1:0] rs);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      q = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask
   // pins need three edges, settings one: five leaves margin
   task automatic settle;
      repeat (5) @(posedge aclk);
   endtask
   // source ids 0 receive pin, 1 transmit pin, 2 baud generator, 3 dpll; three passes tell them apart
   function automatic logic lvl(input int k, input int p);
      return (p == 2) ? ~k[0] : k[p];
   endfunction
   task automatic set_lv(input int p);
      rcv_l <= lvl(0, p); ext_l <= lvl(1, p); brg_clk <= {4{lvl(2, p)}}; dpll_clk <= {4{lvl(3, p)}};
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; awaddr = 0; araddr = 0;
      wdata = 0; wstrb = 0; tx_bit = 0; tx_timeslot = 0; brg_clk = 0; dpll_clk = 0;
      rcv_l = 0; ext_l = 0; rxd_l = 0; cts_l = 0; mismatches = 0; checks_done = 0; cyc = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk(pin_out[0][3:0], 4'h7);
      axr(8'h00, d, r);
      chk(d, 32'h0);
      axr(8'h40, d, r);
      chk(r, SCP_RESP_SLVERR);
      axw(8'h10, 32'h1, r);
      chk(r, SCP_RESP_SLVERR);
      axw(8'h0c, 32'hffffffff, r);
      chk(r, SCP_RESP_OKAY);
      axr(8'h0c, d, r);
      chk(d, 32'h1ff);
      for (int m = 0; m < 8; m++) for (int t = 0; t < 2; t++) for (int s = 0; s < 2; s++) begin
         axw(8'h0c, {27'h0, s[0], t[0], m[2:0]}, r);
         ex_rx = (m % 4 == 3) ? 3 : (m % 4 == 2) ? 2 : 0;
         ex_tx = (m % 4 == 1) ? 0 : !t ? ((!s && m % 2 == 0) ? 1 : 2) : (s && m[1]) ? 2 : (m % 4 == 3) ? 3 : 2;
         ex_oe = t && m[1] && (s || m[0]);
         for (int p = 0; p < 3; p++) begin
            set_lv(p);
            settle();
            chk(core_out[3].rx_clock, lvl(ex_rx, p));
            chk(core_out[3].tx_clock, lvl(ex_tx, p));
            chk(core_out[3].brg_ref, (m == 2 || m == 3) ? lvl(0, p) : 1'b0);
            chk(pin_out[3].transmit_clock_pin_oe, ex_oe);
            if (ex_oe) chk(pin_out[3].transmit_clock_pin_o, lvl(ex_tx, p));
            chk(core_out[3].tx_enable, (m == 1 && !t) ? lvl(1, p) : 1'b1);
            chk(core_out[0].rx_clock, lvl(0, p));
         end
      end
      for (int od = 0; od < 2; od++) for (int b = 0; b < 4; b++) begin
         axw(8'h00, od ? 32'h40 : 32'h0, r);
         tx_bit <= {4{b[0]}};
         cts_l <= b[1];
         settle();
         chk(txd_line[0], b[1] | b[0]);
         chk(pin_out[0].txd_oe, od ? !(b[1] | b[0]) : 1'b1);
         chk(core_out[0].tx_enable, !b[1]);
      end
      cts_l <= 1'b0;
      axw(8'h08, 32'h25, r);
      for (int ts = 0; ts < 2; ts++) begin
         tx_timeslot <= {4{ts[0]}};
         settle();
         chk({pin_out[2].transmit_clock_pin_oe, pin_out[2].transmit_clock_pin_o}, {1'b1, !ts[0]});
      end
      axw(8'h04, 32'h84, r);
      for (int p = 0; p < 2; p++) begin
         set_lv(p);
         settle();
         chk(pin_out[1].rts_n, lvl(1, p));
      end
      axw(8'h04, 32'h100, r);
      settle();
      chk(pin_out[1].rts_n, 1'b0);
      for (int v = 0; v < 2; v++) begin
         rxd_l <= v[0];
         rcv_l <= 1'b0;
         settle();
         rcv_l <= 1'b1;
         pulses = 0;
         // one rising edge of the selected clock must give exactly one sample strobe
         repeat (5) begin
            @(posedge aclk);
            pulses += core_out[0].rx_sample;
         end
         chk(pulses, 1);
         chk(core_out[0].rx_bit, v[0]);
         axr(8'h10, d, r);
         chk(r, SCP_RESP_OKAY);
         chk(d, 32'h18 | (v << 1));
      end
      tally_and_finish();
   end
endmodule // testbench
`default_nettype wire
